// ==== core/spi_params.svh ====
// Constants for the serial port core: offsets, fields, reset values and counts.
// Operation
// - Polarity bit sets idle clock level only
// - Phase bit picks one of two formats
// - Software disables port before changing polarity/phase
// - Slave drives data out only while selected
// - Master's own select held high by others
// - Phase 0: select fall starts, drives MSB
// - Phase 0: master toggles select between bytes
// - Phase 0: no reload after select falls
// - Phase 1: first clock edge starts transfer
// - Phase 1: select may stay low between bytes
// - Phase 1: no reload after first edge
// - Master starts on data write, phase-independent
// - Master first half-bit idle, or leading edge
// - Master divider runs only enabled as master
// - Clock edges placed at fixed bus phase
// - Start delay at most one bit period
// - Queued byte sent right after previous
// - Software writes data only when empty flag set
// - Empty flag set on load, cleared by write
// - Full flag set on receive, cleared status-then-data
// - Without new byte, shift register resent
// - Empty flag returns within two cycles when idle
// - Master select bit picks master or slave
`ifndef SPI_CORE_PARAMS_SVH
`define SPI_CORE_PARAMS_SVH
`define ADDR_CONTROL 2'h0
`define ADDR_STATUS 2'h1
`define ADDR_DATA 2'h2
`define CTRL_ENABLE 0
`define CTRL_MASTER 1
`define CTRL_CPOL 2
`define CTRL_CPHA 3
`define CTRL_RATE_LO 4
`define CTRL_RATE_HI 5
`define CTRL_RESET 6'h00
`define STAT_TX_EMPTY 0
`define STAT_RX_FULL 1
`define STAT_BUSY 2
`define HALF_DIVIDE_BY_TWO 7'h01
`define HALF_DIVIDE_BY_EIGHT 7'h04
`define HALF_DIVIDE_BY_THIRTY_TWO 7'h10
`define HALF_DIVIDE_BY_ONE_TWENTY_EIGHT 7'h40
`define LAST_EDGE 4'hF
`define SELECT_GAP 4'h8
`define BYTE_ZERO 8'h00
`endif

// ==== core/spi_core_pkg.sv ====
// Types shared by the serial port core modules.
package spi_core_pkg;
	typedef enum logic [1:0] {divide_by_two, divide_by_eight, divide_by_thirty_two,
		divide_by_one_twenty_eight} rate_e;
	typedef struct packed {
		logic [2:0] sclk_sy;
		logic [2:0] ss_sy;
		logic [2:0] din_sy;
		logic sclk_st;
		logic ss_st;
		logic din_st;
		logic [6:0] div_cnt;
		logic active;
		logic pending;
		logic [3:0] edge_cnt;
		logic [7:0] shreg;
		logic dout;
		logic sclk_out;
		logic sclk_oe;
		logic mosi_oe;
		logic miso_oe;
		logic done;
	} shift_state_s;
	typedef struct packed {
		logic [5:0] ctrl;
		logic [7:0] tx_buf;
		logic tx_full;
		logic tx_empty_flag;
		logic [7:0] rx_buf;
		logic rx_full_flag;
		logic rx_armed;
		logic [7:0] rdata;
	} device_state_s;
	typedef struct packed {
		logic [7:0] pend_buf;
		logic pend_full;
		logic ss_n;
		logic [3:0] gap;
		logic [7:0] recv_data;
		logic recv_valid;
		logic send_ready;
	} partner_state_s;
endpackage

// ==== core/spi_link_if.sv ====
// Serial link between the documented port and its partner, with wire resolution.
`timescale 1ns/1ps
interface spi_link_if;
	logic dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe;
	logic par_sclk_o, par_sclk_oe, par_mosi_o, par_mosi_oe, par_miso_o, par_miso_oe;
	logic par_ss_n_o, par_ss_n_oe;
	logic sclk, mosi, miso, ss_n;
	// Undriven wires rest high as if pulled up.
	assign sclk = dev_sclk_oe ? dev_sclk_o : (par_sclk_oe ? par_sclk_o : 1'b1);
	assign mosi = dev_mosi_oe ? dev_mosi_o : (par_mosi_oe ? par_mosi_o : 1'b1);
	assign miso = dev_miso_oe ? dev_miso_o : (par_miso_oe ? par_miso_o : 1'b1);
	assign ss_n = par_ss_n_oe ? par_ss_n_o : 1'b1;
	modport dev (output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o,
		dev_miso_oe, input sclk, mosi, miso, ss_n);
	modport par (output par_sclk_o, par_sclk_oe, par_mosi_o, par_mosi_oe, par_miso_o,
		par_miso_oe, par_ss_n_o, par_ss_n_oe, input sclk, mosi, miso);
endinterface

// ==== core/spi_shift_engine.sv ====
// Shared shift engine: pin synchronisers, master clock divider and framing.
//
// Implementation choices: the register addresses and the strobed register port.
`include "spi_params.svh"
`timescale 1ns/1ps
module spi_shift_engine (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic master,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [1:0] rate,
	input wire logic sclk_in,
	input wire logic ss_in_n,
	input wire logic mosi_in,
	input wire logic miso_in,
	input wire logic load,
	input wire logic [7:0] load_data,
	output logic load_ack,
	output logic busy,
	output logic done,
	output logic [7:0] rx_data,
	output logic sclk_out,
	output logic sclk_oe,
	output logic dout,
	output logic mosi_oe,
	output logic miso_oe
);
	spi_core_pkg::shift_state_s r, n;
	logic [6:0] half;
	logic tick, sclk_chg, ss_chg, ss_low, ev, lead, start, sample;
	logic [3:0] cnt;

	// Half bit period for the four rates.
	always_comb
	begin
		case (spi_core_pkg::rate_e'(rate))
			spi_core_pkg::divide_by_two: half = `HALF_DIVIDE_BY_TWO;
			spi_core_pkg::divide_by_eight: half = `HALF_DIVIDE_BY_EIGHT;
			spi_core_pkg::divide_by_thirty_two: half = `HALF_DIVIDE_BY_THIRTY_TWO;
			default: half = `HALF_DIVIDE_BY_ONE_TWENTY_EIGHT;
		endcase
	end

	// Next state: synchronisers first, then divider, start, edges and load.
	always_comb
	begin
		n = r;
		n.done = 1'b0;
		ev = 1'b0;
		lead = 1'b0;
		start = 1'b0;
		n.sclk_sy = {r.sclk_sy[1:0], sclk_in};
		n.ss_sy = {r.ss_sy[1:0], ss_in_n};
		n.din_sy = {r.din_sy[1:0], master ? miso_in : mosi_in};
		sclk_chg = (r.sclk_sy[1] == r.sclk_sy[2]) && (r.sclk_sy[2] != r.sclk_st);
		ss_chg = (r.ss_sy[1] == r.ss_sy[2]) && (r.ss_sy[2] != r.ss_st);
		if (r.sclk_sy[1] == r.sclk_sy[2])
			n.sclk_st = r.sclk_sy[2];
		if (r.ss_sy[1] == r.ss_sy[2])
			n.ss_st = r.ss_sy[2];
		if (r.din_sy[1] == r.din_sy[2])
			n.din_st = r.din_sy[2];
		ss_low = !n.ss_st;
		// Divider free-runs so the start waits at most one bit period.
		tick = enable && master && (r.div_cnt == half - 7'h01);
		if (enable && master)
			n.div_cnt = tick ? 7'h00 : r.div_cnt + 7'h01;
		else
			n.div_cnt = 7'h00;
		if (!r.active)
			n.sclk_out = cpol;
		cnt = r.edge_cnt;
		if (!enable)
		begin
			n.active = 1'b0;
			n.pending = 1'b0;
		end
		else if (master)
		begin
			if (r.pending && tick)
			begin
				start = 1'b1;
				cnt = 4'h0;
				if (!cpha)
					n.dout = r.shreg[7];
				else
				begin
					ev = 1'b1;
					lead = 1'b1;
					n.sclk_out = ~cpol;
				end
			end
			else if (r.active && tick)
			begin
				ev = 1'b1;
				lead = (r.sclk_out == cpol);
				n.sclk_out = ~r.sclk_out;
			end
		end
		else
		begin
			if (r.active && !ss_low)
				n.active = 1'b0;
			else if (!cpha && ss_chg && !r.ss_sy[2] && !r.active)
			begin
				start = 1'b1;
				cnt = 4'h0;
				n.dout = r.shreg[7];
			end
			else if (sclk_chg && ss_low)
			begin
				lead = (r.sclk_st == cpol);
				if (r.active)
					ev = 1'b1;
				else if (cpha && lead)
				begin
					start = 1'b1;
					ev = 1'b1;
					cnt = 4'h0;
				end
			end
		end
		if (start)
		begin
			n.active = 1'b1;
			n.pending = 1'b0;
			n.edge_cnt = 4'h0;
		end
		// Capture and launch edges swap with the phase bit.
		sample = lead ^ cpha;
		if (ev)
		begin
			if (sample)
				n.shreg = {r.shreg[6:0], r.din_st};
			else
				n.dout = r.shreg[7];
			n.edge_cnt = cnt + 4'h1;
			if (cnt == `LAST_EDGE)
			begin
				n.active = 1'b0;
				n.done = 1'b1;
			end
		end
		// The shift register stays locked for the whole transfer.
		load_ack = load && enable && !r.active && !r.pending && !start;
		if (load_ack)
		begin
			n.shreg = load_data;
			n.pending = master;
		end
		n.sclk_oe = enable && master;
		n.mosi_oe = enable && master;
		n.miso_oe = enable && !master && ss_low;
	end

	// State register; clock and select inputs rest high until the first edge after reset.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.sclk_sy <= 3'h7;
			r.ss_sy <= 3'h7;
			r.sclk_st <= 1'b1;
			r.ss_st <= 1'b1;
		end
		else
			r <= n;
	end

	assign busy = r.active || r.pending;
	assign done = r.done;
	assign rx_data = r.shreg;
	assign sclk_out = r.sclk_out;
	assign sclk_oe = r.sclk_oe;
	assign dout = r.dout;
	assign mosi_oe = r.mosi_oe;
	assign miso_oe = r.miso_oe;
endmodule

// ==== core/spi_device_end.sv ====
// Documented port: register file, transmit queue, receive buffer and flags.
`include "spi_params.svh"
`timescale 1ns/1ps
module spi_device_end (
	input wire logic clk,
	input wire logic rst,
	spi_link_if.dev link,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	spi_core_pkg::device_state_s r, n;
	logic load_ack, busy, done, sclk_o, sclk_oe, dout, mosi_oe, miso_oe;
	logic [7:0] rx_data;
	logic port_enable_bit, master_select_bit;

	assign port_enable_bit = r.ctrl[`CTRL_ENABLE];
	assign master_select_bit = r.ctrl[`CTRL_MASTER];

	spi_shift_engine engine (
		.clk(clk),
		.rst(rst),
		.enable(port_enable_bit),
		.master(master_select_bit),
		.cpol(r.ctrl[`CTRL_CPOL]),
		.cpha(r.ctrl[`CTRL_CPHA]),
		.rate(r.ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO]),
		.sclk_in(link.sclk),
		.ss_in_n(link.ss_n),
		.mosi_in(link.mosi),
		.miso_in(link.miso),
		.load(r.tx_full),
		.load_data(r.tx_buf),
		.load_ack(load_ack),
		.busy(busy),
		.done(done),
		.rx_data(rx_data),
		.sclk_out(sclk_o),
		.sclk_oe(sclk_oe),
		.dout(dout),
		.mosi_oe(mosi_oe),
		.miso_oe(miso_oe)
	);

	// Register accesses and flag bookkeeping.
	always_comb
	begin
		n = r;
		n.rdata = `BYTE_ZERO;
		// Control writes take effect at once; changing format bits while enabled
		// is the caller's hazard and is not blocked here.
		if (wr && addr == `ADDR_CONTROL)
			n.ctrl = wdata[5:0];
		// A data write queues the byte and clears the empty flag.
		if (wr && addr == `ADDR_DATA)
		begin
			n.tx_buf = wdata;
			n.tx_full = 1'b1;
			n.tx_empty_flag = 1'b0;
		end
		// The engine takes the queued byte only when idle, so an active slave
		// keeps it until its transfer has ended.
		if (load_ack)
		begin
			n.tx_full = 1'b0;
			n.tx_empty_flag = 1'b1;
		end
		if (wr && addr == `ADDR_DATA && load_ack)
		begin
			n.tx_full = 1'b1;
			n.tx_empty_flag = 1'b0;
		end
		// A status read with the flag set arms the clear for the next data read.
		if (rd && addr == `ADDR_STATUS)
			n.rx_armed = r.rx_full_flag;
		if (rd && addr == `ADDR_DATA)
		begin
			if (r.rx_armed)
				n.rx_full_flag = 1'b0;
			n.rx_armed = 1'b0;
		end
		// A new byte wins over a clear in the same cycle.
		if (done)
		begin
			n.rx_buf = rx_data;
			n.rx_full_flag = 1'b1;
		end
		// Disabling the port drops the queued byte and reports the buffer empty.
		if (!port_enable_bit)
		begin
			n.tx_full = 1'b0;
			n.tx_empty_flag = 1'b1;
		end
		// Read data answers in the cycle after the strobe.
		if (rd)
		begin
			case (addr)
				`ADDR_CONTROL: n.rdata = {2'h0, r.ctrl};
				`ADDR_STATUS: n.rdata = {5'h00, busy, r.rx_full_flag, r.tx_empty_flag};
				`ADDR_DATA: n.rdata = r.rx_buf;
				default: n.rdata = `BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.ctrl <= `CTRL_RESET;
			r.tx_empty_flag <= 1'b1;
		end
		else
			r <= n;
	end

	// Pin drivers come straight from engine flip-flops; the same data bit feeds
	// whichever data line the current role owns.
	assign link.dev_sclk_o = sclk_o;
	assign link.dev_sclk_oe = sclk_oe;
	assign link.dev_mosi_o = dout;
	assign link.dev_mosi_oe = mosi_oe;
	assign link.dev_miso_o = dout;
	assign link.dev_miso_oe = miso_oe;
	assign rdata = r.rdata;
endmodule

// ==== core/spi_partner_end.sv ====
// Partner end: a master or slave peer that also drives the slave-select line.
`include "spi_params.svh"
`timescale 1ns/1ps
module spi_partner_end (
	input wire logic clk,
	input wire logic rst,
	spi_link_if.par link,
	input wire logic enable,
	input wire logic act_as_master,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [1:0] rate,
	input wire logic send,
	input wire logic [7:0] send_data,
	output logic send_ready,
	output logic [7:0] recv_data,
	output logic recv_valid
);
	spi_core_pkg::partner_state_s r, n;
	logic load, load_ack, busy, done, sclk_o, sclk_oe, dout, mosi_oe, miso_oe;
	logic [7:0] rx_data;

	// A master loads only after select has been low for the settle gap. In phase 0 the
	// cycle that ends a byte must not load, or the next byte would leave with select high.
	assign load = r.pend_full && (!act_as_master ||
		(!r.ss_n && r.gap == 4'h0 && !(done && !cpha)));

	spi_shift_engine engine (
		.clk(clk),
		.rst(rst),
		.enable(enable),
		.master(act_as_master),
		.cpol(cpol),
		.cpha(cpha),
		.rate(rate),
		.sclk_in(link.sclk),
		.ss_in_n(1'b0),
		.mosi_in(link.mosi),
		.miso_in(link.miso),
		.load(load),
		.load_data(r.pend_buf),
		.load_ack(load_ack),
		.busy(busy),
		.done(done),
		.rx_data(rx_data),
		.sclk_out(sclk_o),
		.sclk_oe(sclk_oe),
		.dout(dout),
		.mosi_oe(mosi_oe),
		.miso_oe(miso_oe)
	);

	// Byte hand-off and slave-select sequencing.
	always_comb
	begin
		n = r;
		n.recv_valid = done;
		if (done)
			n.recv_data = rx_data;
		if (send && r.send_ready)
		begin
			n.pend_buf = send_data;
			n.pend_full = 1'b1;
		end
		if (load_ack)
			n.pend_full = 1'b0;
		n.send_ready = !n.pend_full;
		// As slave, keep the other end's select high.
		if (!enable || !act_as_master)
		begin
			n.ss_n = 1'b1;
			n.gap = 4'h0;
		end
		else if (done && !cpha)
		begin
			n.ss_n = 1'b1;
			n.gap = `SELECT_GAP;
		end
		else if (r.gap != 4'h0)
			n.gap = r.gap - 4'h1;
		else if (r.pend_full && r.ss_n)
		begin
			n.ss_n = 1'b0;
			n.gap = `SELECT_GAP;
		end
		else if (!busy && !r.pend_full && !cpha)
			n.ss_n = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.ss_n <= 1'b1;
			r.send_ready <= 1'b1;
		end
		else
			r <= n;
	end

	assign link.par_sclk_o = sclk_o;
	assign link.par_sclk_oe = sclk_oe;
	assign link.par_mosi_o = dout;
	assign link.par_mosi_oe = mosi_oe;
	assign link.par_miso_o = dout;
	assign link.par_miso_oe = miso_oe;
	assign link.par_ss_n_o = r.ss_n;
	assign link.par_ss_n_oe = 1'b1;
	assign send_ready = r.send_ready;
	assign recv_data = r.recv_data;
	assign recv_valid = r.recv_valid;
endmodule

// ==== testbench/spi_transfer_format_core_asserts.sv ====
// Assertions on the link wires between the documented port and its partner.
`timescale 1ns/1ps
module spi_link_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic dev_sclk_oe,
	input wire logic dev_mosi_oe,
	input wire logic dev_miso_oe,
	input wire logic par_sclk_oe,
	input wire logic par_miso_oe,
	input wire logic ss_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Seven cycles cover the three-stage synchroniser plus the driver flop.
	sequence sel_fall;
		$fell(ss_n) && par_sclk_oe;
	endsequence
	sequence sel_held;
		(!ss_n && par_sclk_oe) [*7];
	endsequence
	sequence unsel_held;
		ss_n [*7];
	endsequence
	a_one_clock_driver: assert property (!(dev_sclk_oe && par_sclk_oe))
		else $error("both ends drive the clock");
	a_one_miso_driver: assert property (!(dev_miso_oe && par_miso_oe))
		else $error("both ends drive miso");
	a_slave_start_drive: assert property (sel_fall |-> ##[1:6] dev_miso_oe)
		else $error("selected slave late to drive miso");
	a_sel_miso_on: assert property (sel_held |-> dev_miso_oe)
		else $error("selected slave not driving miso");
	a_unsel_miso_off: assert property (unsel_held |-> !dev_miso_oe)
		else $error("unselected slave drives miso");
	a_master_ss_idle: assert property (dev_sclk_oe |-> ss_n)
		else $error("select low while port is master");
	a_master_pins_out: assert property (dev_sclk_oe == dev_mosi_oe)
		else $error("master clock and data drivers disagree");
	a_master_miso_in: assert property (dev_sclk_oe |-> !dev_miso_oe)
		else $error("master port drives miso");
endmodule

// ==== testbench/spi_transfer_format_core_tb_top.sv ====
// Self-checking bench joining the documented port to its partner.
`include "spi_params.svh"
`timescale 1ns/1ps
module spi_transfer_format_core_tb_top;
	logic clk, rst, wr, rd, p_en, p_mst, p_cpol, p_cpha, p_send, p_ready, p_valid;
	logic [1:0] addr, p_rate;
	logic [7:0] wdata, rdata, p_data, p_rx;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	spi_link_if u_spi_link_if ();
	spi_device_end u_spi_device_end (.clk(clk), .rst(rst), .link(u_spi_link_if), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	spi_partner_end u_spi_partner_end (.clk(clk), .rst(rst), .link(u_spi_link_if),
		.enable(p_en), .act_as_master(p_mst), .cpol(p_cpol), .cpha(p_cpha), .rate(p_rate),
		.send(p_send), .send_data(p_data), .send_ready(p_ready), .recv_data(p_rx),
		.recv_valid(p_valid));
	spi_link_checker u_spi_link_checker (.clk(clk), .rst(rst),
		.dev_sclk_oe(u_spi_link_if.dev_sclk_oe), .dev_mosi_oe(u_spi_link_if.dev_mosi_oe),
		.dev_miso_oe(u_spi_link_if.dev_miso_oe), .par_sclk_oe(u_spi_link_if.par_sclk_oe),
		.par_miso_oe(u_spi_link_if.par_miso_oe), .ss_n(u_spi_link_if.ss_n));
	// Bus clock at 40 MHz.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// A hang is cut short well past the longest expected run.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bus cycles end one edge late so no strobe is assigned twice in a time step.
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		check(d, exp);
	endtask
	task automatic recv_chk(input logic [7:0] exp);
		for (int i = 0; i < 3000; i++)
		begin
			@(negedge clk);
			if (p_valid === 1'b1)
				break;
		end
		check(p_rx, exp);
		@(posedge clk);
	endtask
	task automatic psend(input logic [7:0] d);
		for (int i = 0; i < 3000; i++)
		begin
			@(negedge clk);
			if (p_ready === 1'b1)
				break;
		end
		@(posedge clk);
		p_send <= 1'h1;
		p_data <= d;
		@(posedge clk);
		p_send <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wait_idle;
		logic [7:0] d;
		for (int i = 0; i < 1000; i++)
		begin
			rd_reg(`ADDR_STATUS, d);
			if (d[`STAT_BUSY] === 1'b0)
				break;
		end
	endtask
	// Master, idle low, phase 1 on even rates and 0 on odd: write to first clock edge.
	task automatic t_latency;
		int n;
		logic [7:0] c;
		for (int r = 0; r < 4; r++)
		begin
			c = {2'h0, r[1:0], r[0] ? 4'h3 : 4'hB};
			wr_reg(`ADDR_CONTROL, c);
			rd_chk(`ADDR_CONTROL, c);
			wr_reg(`ADDR_DATA, 8'h81);
			for (n = 0; n < 300; n++)
			begin
				@(negedge clk);
				if (u_spi_link_if.sclk === 1'b1)
					break;
			end
			checked++;
			if (n > (2 << (2 * r)) + 2)
			begin
				n_fail++;
				$display("FAIL %0t start delay %0d at rate %0d", $time, n, r);
			end
			@(posedge clk);
			wait_idle();
			// The partner is off, so the released miso line reads back as all ones.
			rd_chk(`ADDR_STATUS, 8'h03);
			rd_chk(`ADDR_DATA, 8'hFF);
			rd_chk(`ADDR_STATUS, 8'h01);
			wr_reg(`ADDR_CONTROL, 8'h00);
		end
	endtask
	// Master with a queued second byte; the partner listens as slave.
	task automatic t_master;
		logic [7:0] d;
		p_en <= 1'h1;
		p_mst <= 1'h0;
		p_cpol <= 1'h1;
		p_cpha <= 1'h1;
		psend(8'hA5);
		wr_reg(`ADDR_CONTROL, 8'h2F);
		@(negedge clk);
		check({7'h00, u_spi_link_if.sclk}, 8'h01);
		@(posedge clk);
		wr_reg(`ADDR_DATA, 8'h3C);
		rd_reg(`ADDR_STATUS, d);
		check(d & 8'h03, 8'h01);
		wr_reg(`ADDR_DATA, 8'hC3);
		rd_reg(`ADDR_STATUS, d);
		check(d & 8'h01, 8'h00);
		recv_chk(8'h3C);
		repeat (8) @(posedge clk);
		rd_reg(`ADDR_STATUS, d);
		check(d & 8'h02, 8'h02);
		rd_chk(`ADDR_DATA, 8'hA5);
		rd_reg(`ADDR_STATUS, d);
		check(d & 8'h02, 8'h00);
		recv_chk(8'hC3);
		wait_idle();
		// The partner wrote nothing new, so it sent back what it had just received.
		rd_chk(`ADDR_STATUS, 8'h03);
		rd_chk(`ADDR_DATA, 8'h3C);
		p_en <= 1'h0;
		wr_reg(`ADDR_CONTROL, 8'h00);
	endtask
	// Port as slave: byte b is written after the start and must wait for the next byte.
	task automatic t_slave(input logic cp, input logic ph, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] x, input logic [7:0] y);
		logic [7:0] d;
		p_en <= 1'h1;
		p_mst <= 1'h1;
		p_cpol <= cp;
		p_cpha <= ph;
		wr_reg(`ADDR_CONTROL, {2'h0, 2'h2, ph, cp, 2'h1});
		wr_reg(`ADDR_DATA, a);
		repeat (3) @(posedge clk);
		psend(x);
		for (int i = 0; i < 3000; i++)
		begin
			@(negedge clk);
			if (ph ? u_spi_link_if.sclk !== cp : u_spi_link_if.ss_n === 1'b0)
				break;
		end
		repeat (6) @(posedge clk);
		wr_reg(`ADDR_DATA, b);
		psend(y);
		recv_chk(a);
		recv_chk(b);
		repeat (8) @(posedge clk);
		rd_reg(`ADDR_STATUS, d);
		check(d & 8'h02, 8'h02);
		rd_chk(`ADDR_DATA, y);
		p_en <= 1'h0;
		wr_reg(`ADDR_CONTROL, 8'h00);
	endtask
	// Reset, then each scenario in turn.
	initial
	begin
		rst = 1'h1;
		{wr, rd, p_en, p_mst, p_cpol, p_cpha, p_send} = 7'h00;
		addr = 2'h0;
		wdata = 8'h00;
		p_data = 8'h00;
		p_rate = 2'h2;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rd_chk(`ADDR_CONTROL, 8'h00);
		rd_chk(`ADDR_STATUS, 8'h01);
		wr_reg(2'h3, 8'hFF);
		rd_chk(2'h3, 8'h00);
		t_latency();
		t_master();
		t_slave(1'h0, 1'h0, 8'h96, 8'h4B, 8'h69, 8'hD2);
		t_slave(1'h1, 1'h1, 8'h5A, 8'h77, 8'h33, 8'hEE);
		report_and_stop();
	end
endmodule
